// File: hw/flash_call_pkg.sv
// constants and types shared by the supervisory flash call unit
package flash_call_pkg;
	// ****************************************
	// call decoding
	// ****************************************
	localparam logic [7:0] SSC_OPCODE   = 8'h00;
	localparam logic [7:0] FN_BOOT      = 8'h00;
	localparam logic [7:0] FN_READ      = 8'h01;
	localparam logic [7:0] FN_WRITE     = 8'h02;
	localparam logic [7:0] FN_ERASE     = 8'h03;
	localparam logic [7:0] FN_WHOLE     = 8'h05;
	localparam logic [7:0] FN_TABLE     = 8'h06;
	localparam logic [7:0] FN_CHECKSUM  = 8'h07;
	localparam logic [7:0] FIRST_GUARD_KEY_VALUE   = 8'h3a;
	localparam logic [7:0] SP_CALL_ADJ  = 8'h03;
	// stack bytes used per function
	localparam logic [3:0] STK_BOOT     = 4'h0;
	localparam logic [3:0] STK_READ     = 4'h7;
	localparam logic [3:0] STK_WRITE    = 4'ha;
	localparam logic [3:0] STK_ERASE    = 4'h9;
	localparam logic [3:0] STK_WHOLE    = 4'hb;
	localparam logic [3:0] STK_TABLE    = 4'h3;
	localparam logic [3:0] STK_CHECKSUM = 4'h3;
	// ****************************************
	// parameter block in data ram page 0
	// ****************************************
	localparam logic [7:0] PRM_FIRST_GUARD_KEY     = 8'hf8;
	localparam logic [7:0] PRM_SECOND_GUARD_KEY     = 8'hf9;
	localparam logic [7:0] PRM_BLOCK    = 8'hfa;
	localparam logic [7:0] PRM_POINTER  = 8'hfb;
	localparam logic [1:0] PRM_LAST_IDX = 2'h3;
	// ****************************************
	// return codes and protection levels
	// ****************************************
	localparam logic [7:0] RC_OK        = 8'h00;
	localparam logic [7:0] RC_PROTECT   = 8'h01;
	localparam logic [7:0] RC_SW_RESET  = 8'h02;
	localparam logic [7:0] RC_FATAL     = 8'h03;
	localparam logic [1:0] PL_READ_PROT = 2'h1;
	localparam logic [1:0] PL_NO_EXT_WR = 2'h2;
	localparam logic [1:0] PL_NO_INT_WR = 2'h3;
	localparam logic [5:0] BLOCK_LAST   = 6'h3f;
	// ****************************************
	// apb register map
	// ****************************************
	localparam logic [7:0] REG_STATUS   = 8'h00;
	localparam logic [7:0] REG_CONFIG   = 8'h04;
	localparam logic [7:0] REG_PROT_SEL = 8'h08;
	localparam logic [7:0] REG_PROT_LVL = 8'h0c;
	localparam logic       CONFIG_RST   = 1'b1;
	// flash macro commands
	typedef enum logic [2:0] {
		FL_READ, FL_PROG, FL_ERASE_BLK, FL_ERASE_MACRO,
		FL_ZERO_MACRO, FL_READ_AUX, FL_ERASE_PROT, FL_ZERO_PROT
	} fl_cmd_t;
endpackage

// File: hw/call_check_if.sv
// key check and function decode signals between the sequencer and its checker
`timescale 1ns/1ps
`default_nettype none
interface call_check_if;
	logic [7:0] func;
	logic [7:0] first_guard_key;
	logic [7:0] second_guard_key;
	logic [7:0] sp_expect;
	logic       func_known;
	logic       keys_ok;
	logic [3:0] stack_use;
	modport chk (input func, first_guard_key, second_guard_key, sp_expect, output func_known, keys_ok, stack_use);
	modport seq (output func, first_guard_key, second_guard_key, sp_expect, input func_known, keys_ok, stack_use);
endinterface
`default_nettype wire

// File: hw/call_check.sv
// function code decode, stack use and guard key comparison
`timescale 1ns/1ps
`default_nettype none
module call_check (
	call_check_if.chk chk
);
	always_comb begin
		chk.func_known = 1'b1;
		chk.stack_use  = flash_call_pkg::STK_BOOT;
		case (chk.func)
			flash_call_pkg::FN_BOOT:     chk.stack_use = flash_call_pkg::STK_BOOT;
			flash_call_pkg::FN_READ:     chk.stack_use = flash_call_pkg::STK_READ;
			flash_call_pkg::FN_WRITE:    chk.stack_use = flash_call_pkg::STK_WRITE;
			flash_call_pkg::FN_ERASE:    chk.stack_use = flash_call_pkg::STK_ERASE;
			flash_call_pkg::FN_WHOLE:    chk.stack_use = flash_call_pkg::STK_WHOLE;
			flash_call_pkg::FN_TABLE:    chk.stack_use = flash_call_pkg::STK_TABLE;
			flash_call_pkg::FN_CHECKSUM: chk.stack_use = flash_call_pkg::STK_CHECKSUM;
			default:                     chk.func_known = 1'b0;
		endcase
		// first key must be the fixed value
		// second key is stack pointer plus three
		chk.keys_ok = (chk.first_guard_key == flash_call_pkg::FIRST_GUARD_KEY_VALUE) && (chk.second_guard_key == chk.sp_expect);
	end
endmodule // call_check
`default_nettype wire

// File: hw/supervisory_flash_call_unit.sv
// supervisory call sequencer for flash read, write, erase, table read and checksum
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Function
// - opcode 00h is the supervisory call entering supervisory rom.
// - codes 00 boot,01 read,02 write,03 erase,05 whole,06 table,07 checksum.
// - undefined function code from user code halts the processor.
// - first guard key must hold 3Ah at call time.
// - second guard key equals stack pointer at call plus three.
// - a key mismatch halts; boot reset skips the key check.
// - parameter block sits at page 0 addresses F8h to FBh.
// - stack use per function 0,7,10,9,11,3,3 bytes.
// - return code is written into the first key slot on completion.
// - codes 00 ok, 01 protected, 02 software reset, 03 fatal halt.
// - table read returns data in the first key slot, checksum in the first and second key slots.
// - flash control registers reachable only while supervisory code executes.
// - block read, write, erase refused when protection level forbids it.
// - whole erase does erase, zero, erase per macro, then protection blocks.
// - device erase never touches the four auxiliary rows.
// - serial programming mode over the usb data pins issues flash calls.
// - block read copies 64 flash bytes to ram at the pointer.
// - on refusal accumulator and second key cleared, first key gets 01h.
module supervisory_flash_call_unit #(
	parameter int NUM_MACROS = 1
) (
	// clock and reset
	input  wire logic                    i_clk,
	input  wire logic                    i_rst,
	// cpu call request
	input  wire logic                    i_call_valid,
	input  wire logic [7:0]              i_opcode,
	input  wire logic [7:0]              i_acc,
	input  wire logic [7:0]              i_sp,
	input  wire logic                    i_exec_supervisory,
	// cpu return
	output logic                         o_resume,
	output logic                         o_resume_to_boot,
	output logic [7:0]                   o_acc,
	output logic                         o_halt,
	output logic                         o_busy,
	output logic [3:0]                   o_stack_use,
	// serial programming pins and test queue
	input  wire logic                    i_usb_dp,
	input  wire logic                    i_usb_dm,
	input  wire logic                    i_tq_valid,
	input  wire logic [7:0]              i_tq_func,
	input  wire logic [7:0]              i_tq_sp,
	output logic                         o_prog_mode,
	// data ram port, read data valid the cycle after o_ram_re
	output logic [7:0]                   o_ram_addr,
	output logic [7:0]                   o_ram_wdata,
	output logic                         o_ram_we,
	output logic                         o_ram_re,
	input  wire logic [7:0]              i_ram_rdata,
	// flash macro port
	output logic                         o_fl_req,
	output flash_call_pkg::fl_cmd_t      o_fl_cmd,
	output logic [12:0]                  o_fl_addr,
	output logic [3:0]                   o_fl_macro,
	output logic [7:0]                   o_fl_wdata,
	input  wire logic                    i_fl_done,
	input  wire logic [7:0]              i_fl_rdata,
	// apb slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic [31:0]                  prdata,
	output logic                         pready,
	output logic                         pslverr
);
	typedef enum logic [3:0] {
		S_BOOT, S_IDLE, S_PRD, S_PWT, S_PCAP, S_CHECK, S_FRD, S_FWT,
		S_WRD, S_WWT, S_WCAP, S_EA, S_RCW1, S_RCW2, S_DONE, S_HALT
	} state_t;
	typedef struct packed {
		state_t                  st;
		flash_call_pkg::fl_cmd_t fl_cmd;
		logic [255:0]            prot;
		logic [31:0]             prdata;
		logic [15:0]             sum;
		logic [12:0]             faddr, fl_addr;
		logic [7:0]              func, spx, first_guard_key, second_guard_key, blk, ptr, rc, k2v, acc, ram_addr, ram_wdata, fl_wdata;
		logic [6:0]              prot_sel;
		logic [3:0]              macro, stack;
		logic [2:0]              step, dp_s, dm_s;
		logic [1:0]              pidx;
		logic                    from_tq, wr_k2, resume, to_boot, halt, fatal, ram_we, ram_re, fl_req, pmode;
		logic                    cfg_prog_en, pslverr;
	} regs_t;
	regs_t r, r_nxt;
	call_check_if cc ();
	call_check u_check (.chk (cc.chk));
	assign {cc.func, cc.first_guard_key, cc.second_guard_key, cc.sp_expect} = {r.func, r.first_guard_key, r.second_guard_key, r.spx};
	// ****************************************
	// sequencer and register file
	// ****************************************
	logic [12:0] blk_base;
	logic [1:0]  lvl;
	logic        refuse, last_byte, apb_ok;
	always_comb begin
		lvl       = r.prot[{r.blk[6:0], 1'b0} +: 2];
		blk_base  = {r.blk[6:0], 6'h00};
		last_byte = (r.faddr[5:0] == flash_call_pkg::BLOCK_LAST);
		refuse    = (r.func == flash_call_pkg::FN_READ) ? (lvl == flash_call_pkg::PL_READ_PROT) :
			(lvl == flash_call_pkg::PL_NO_INT_WR) || (r.from_tq && (lvl == flash_call_pkg::PL_NO_EXT_WR));
		// control registers only while executing supervisory code
		apb_ok = i_exec_supervisory;
		r_nxt        = r;
		r_nxt.resume = 1'b0;
		r_nxt.ram_we = 1'b0;
		r_nxt.ram_re = 1'b0;
		r_nxt.fl_req = 1'b0;
		// three stage sync, level taken once stages two and three agree
		r_nxt.dp_s = {r.dp_s[1:0], i_usb_dp};
		r_nxt.dm_s = {r.dm_s[1:0], i_usb_dm};
		if ((r.dp_s[1] == r.dp_s[2]) && (r.dm_s[1] == r.dm_s[2])) begin
			r_nxt.pmode = r.dp_s[2] && r.dm_s[2] && r.cfg_prog_en;
		end
		case (r.st)
			S_BOOT: begin
				// hardware reset runs boot reset, then user code starts
				r_nxt.resume  = 1'b1;
				r_nxt.to_boot = 1'b1;
				r_nxt.acc     = flash_call_pkg::RC_OK;
				r_nxt.st      = S_IDLE;
			end
			S_IDLE: begin
				r_nxt.to_boot = 1'b0;
				// outside programming mode only opcode 00h enters the sequencer; in programming mode the test queue does
				// function code taken from the accumulator, or from i_tq_func in programming mode
				if (r.pmode && i_tq_valid) begin
					r_nxt.func    = i_tq_func;
					r_nxt.spx     = i_tq_sp + flash_call_pkg::SP_CALL_ADJ;
					r_nxt.from_tq = 1'b1;
					r_nxt.st      = S_PRD;
				end else if (!r.pmode && i_call_valid && (i_opcode == flash_call_pkg::SSC_OPCODE)) begin
					r_nxt.func    = i_acc;
					r_nxt.spx     = i_sp + flash_call_pkg::SP_CALL_ADJ;
					r_nxt.from_tq = 1'b0;
					r_nxt.st      = S_PRD;
				end
				r_nxt.pidx = 2'h0;
			end
			S_CHECK: begin
				r_nxt.stack = cc.stack_use;
				if (r.func == flash_call_pkg::FN_BOOT) begin
					// software boot reset reports code 02h
					r_nxt.rc      = flash_call_pkg::RC_SW_RESET;
					r_nxt.wr_k2   = 1'b0;
					r_nxt.to_boot = 1'b1;
					r_nxt.st      = S_RCW1;
				end else if (!cc.func_known || !cc.keys_ok) begin
					r_nxt.rc    = flash_call_pkg::RC_FATAL;
					r_nxt.wr_k2 = 1'b0;
					r_nxt.fatal = 1'b1;
					r_nxt.st    = r.from_tq ? S_RCW1 : S_HALT;
				end else begin
					r_nxt.rc    = flash_call_pkg::RC_OK;
					r_nxt.k2v   = flash_call_pkg::RC_OK;
					r_nxt.wr_k2 = 1'b1;
					r_nxt.faddr = blk_base;
					r_nxt.sum   = 16'h0000;
					r_nxt.macro = 4'h0;
					r_nxt.step  = 3'h0;
					case (r.func)
						flash_call_pkg::FN_READ,
						flash_call_pkg::FN_WRITE,
						flash_call_pkg::FN_ERASE: begin
							if (refuse) begin
								// refused call clears acc and second_guard_key, first_guard_key gets 01h
								r_nxt.rc = flash_call_pkg::RC_PROTECT;
								r_nxt.st = S_RCW1;
							end else if (r.func == flash_call_pkg::FN_READ) begin
								r_nxt.st = S_FRD;
							end else if (r.func == flash_call_pkg::FN_WRITE) begin
								r_nxt.st = S_WRD;
							end else begin
								r_nxt.fl_req  = 1'b1;
								r_nxt.fl_cmd  = flash_call_pkg::FL_ERASE_BLK;
								r_nxt.fl_addr = blk_base;
								r_nxt.st      = S_FWT;
							end
						end
						flash_call_pkg::FN_WHOLE: r_nxt.st = S_EA;
						flash_call_pkg::FN_TABLE: begin
							r_nxt.fl_req  = 1'b1;
							r_nxt.fl_cmd  = flash_call_pkg::FL_READ_AUX;
							r_nxt.fl_addr = {5'h00, r.blk};
							r_nxt.wr_k2   = 1'b0;
							r_nxt.st      = S_FWT;
						end
						default: begin
							r_nxt.faddr = 13'h0000;
							r_nxt.st    = S_FRD;
						end
					endcase
				end
			end
			S_PRD: begin
				// keys, block and pointer from page 0
				r_nxt.ram_re   = 1'b1;
				r_nxt.ram_addr = flash_call_pkg::PRM_FIRST_GUARD_KEY + {6'h00, r.pidx};
				r_nxt.st       = S_PWT;
			end
			S_PWT: r_nxt.st = S_PCAP;
			S_PCAP: begin
				case (r.pidx)
					2'h0:    r_nxt.first_guard_key = i_ram_rdata;
					2'h1:    r_nxt.second_guard_key = i_ram_rdata;
					2'h2:    r_nxt.blk  = i_ram_rdata;
					default: r_nxt.ptr  = i_ram_rdata;
				endcase
				r_nxt.pidx = r.pidx + 2'h1;
				r_nxt.st   = (r.pidx == flash_call_pkg::PRM_LAST_IDX) ? S_CHECK : S_PRD;
			end
			S_FRD: begin
				r_nxt.fl_req  = 1'b1;
				r_nxt.fl_cmd  = flash_call_pkg::FL_READ;
				r_nxt.fl_addr = r.faddr;
				r_nxt.st      = S_FWT;
			end
			S_WRD: begin
				r_nxt.ram_re   = 1'b1;
				r_nxt.ram_addr = r.ptr + {2'h0, r.faddr[5:0]};
				r_nxt.st       = S_WWT;
			end
			S_WWT: r_nxt.st = S_WCAP;
			S_WCAP: begin
				r_nxt.fl_req   = 1'b1;
				r_nxt.fl_cmd   = flash_call_pkg::FL_PROG;
				r_nxt.fl_addr  = r.faddr;
				r_nxt.fl_wdata = i_ram_rdata;
				r_nxt.st       = S_FWT;
			end
			S_EA: begin
				// erase, zero, erase per macro, then protection pass
				// auxiliary rows are never a target here
				r_nxt.fl_req  = 1'b1;
				r_nxt.fl_addr = 13'h0000;
				case (r.step)
					3'h0, 3'h2: r_nxt.fl_cmd = flash_call_pkg::FL_ERASE_MACRO;
					3'h1:       r_nxt.fl_cmd = flash_call_pkg::FL_ZERO_MACRO;
					3'h3:       r_nxt.fl_cmd = flash_call_pkg::FL_ERASE_PROT;
					default:    r_nxt.fl_cmd = flash_call_pkg::FL_ZERO_PROT;
				endcase
				r_nxt.st = S_FWT;
			end
			S_FWT: begin
				if (i_fl_done) begin
					r_nxt.faddr = r.faddr + 13'h0001;
					r_nxt.st    = S_RCW1;
					case (r.func)
						flash_call_pkg::FN_READ: begin
							// 64 bytes land in ram from the pointer on
							r_nxt.ram_we    = 1'b1;
							r_nxt.ram_addr  = r.ptr + {2'h0, r.faddr[5:0]};
							r_nxt.ram_wdata = i_fl_rdata;
							r_nxt.st        = last_byte ? S_RCW1 : S_FRD;
						end
						flash_call_pkg::FN_WRITE: r_nxt.st = last_byte ? S_RCW1 : S_WRD;
						flash_call_pkg::FN_WHOLE: begin
							r_nxt.st = S_EA;
							if (r.step == 3'h2 && r.macro != NUM_MACROS[3:0] - 4'h1) begin
								r_nxt.macro = r.macro + 4'h1;
								r_nxt.step  = 3'h0;
							end else if (r.step == 3'h4) begin
								r_nxt.prot = '0;
								r_nxt.st   = S_RCW1;
							end else begin
								r_nxt.step = r.step + 3'h1;
							end
						end
						flash_call_pkg::FN_TABLE: begin
							// table data replaces the return code
							r_nxt.rc = i_fl_rdata;
						end
						flash_call_pkg::FN_CHECKSUM: begin
							r_nxt.sum = r.sum + {8'h00, i_fl_rdata};
							// checksum returned in the key slots
							r_nxt.rc  = r.sum[7:0] + i_fl_rdata;
							r_nxt.k2v = r.sum[15:8] + {7'h00, (({1'b0, r.sum[7:0]} + {1'b0, i_fl_rdata}) > 9'h0ff)};
							if (!(last_byte && r.faddr[12:6] == r.blk[6:0])) begin
								r_nxt.st = S_FRD;
							end
						end
						default: ;
					endcase
				end
			end
			S_RCW1: begin
				// completion code into first key slot
				r_nxt.ram_we    = 1'b1;
				r_nxt.ram_addr  = flash_call_pkg::PRM_FIRST_GUARD_KEY;
				r_nxt.ram_wdata = r.rc;
				r_nxt.st        = r.wr_k2 ? S_RCW2 : (r.fatal ? S_HALT : S_DONE);
			end
			S_RCW2: begin
				r_nxt.ram_we    = 1'b1;
				r_nxt.ram_addr  = flash_call_pkg::PRM_SECOND_GUARD_KEY;
				r_nxt.ram_wdata = r.k2v;
				r_nxt.st        = S_DONE;
			end
			S_DONE: begin
				// return to the instruction after the call
				r_nxt.resume = 1'b1;
				r_nxt.acc    = flash_call_pkg::RC_OK;
				r_nxt.st     = S_IDLE;
			end
			S_HALT: r_nxt.halt = 1'b1;
			default: r_nxt.st = S_IDLE;
		endcase
		if (psel && !penable) begin
			r_nxt.prdata  = 32'h0000_0000;
			r_nxt.pslverr = !apb_ok;
			case (paddr)
				flash_call_pkg::REG_STATUS:   r_nxt.prdata = {16'h0000, r.rc, 5'h00, r.pmode, o_busy, r.halt};
				flash_call_pkg::REG_CONFIG:   r_nxt.prdata = {31'h0000_0000, r.cfg_prog_en};
				flash_call_pkg::REG_PROT_SEL: r_nxt.prdata = {25'h000_0000, r.prot_sel};
				flash_call_pkg::REG_PROT_LVL: r_nxt.prdata = {30'h0000_0000, r.prot[{r.prot_sel, 1'b0} +: 2]};
				default:                      r_nxt.pslverr = 1'b1;
			endcase
			if (!apb_ok) begin
				r_nxt.prdata = 32'h0000_0000;
			end
		end
		// writes land only when supervisory code is running
		if (psel && penable && pwrite && !r.pslverr) begin
			case (paddr)
				flash_call_pkg::REG_CONFIG:   r_nxt.cfg_prog_en = pwdata[0];
				flash_call_pkg::REG_PROT_SEL: r_nxt.prot_sel = pwdata[6:0];
				flash_call_pkg::REG_PROT_LVL: r_nxt.prot[{r.prot_sel, 1'b0} +: 2] = pwdata[1:0];
				default: ;
			endcase
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			r             <= '0;
			r.st          <= S_BOOT;
			r.fl_cmd      <= flash_call_pkg::FL_READ;
			r.cfg_prog_en <= flash_call_pkg::CONFIG_RST;
		end else begin
			r <= r_nxt;
		end
	end
	// ****************************************
	// outputs
	// ****************************************
	assign {o_resume, o_resume_to_boot, o_acc, o_halt} = {r.resume, r.to_boot, r.acc, r.halt};
	assign {o_stack_use, o_prog_mode, o_ram_addr, o_ram_wdata} = {r.stack, r.pmode, r.ram_addr, r.ram_wdata};
	assign {o_ram_we, o_ram_re, o_fl_req, o_fl_addr, o_fl_macro} = {r.ram_we, r.ram_re, r.fl_req, r.fl_addr, r.macro};
	assign {o_fl_wdata, prdata, pslverr} = {r.fl_wdata, r.prdata, r.pslverr};
	assign o_fl_cmd = r.fl_cmd;
	assign o_busy   = (r.st != S_IDLE) && (r.st != S_HALT);
	assign pready   = 1'b1;
endmodule // supervisory_flash_call_unit
`default_nettype wire

// File: verification/flash_call_asserts.sv
// port assertions for the supervisory flash call unit
`timescale 1ns/1ps
`default_nettype none
module flash_call_asserts (
	// clock and reset
	input wire logic                    i_clk,
	input wire logic                    i_rst,
	// cpu side
	input wire logic                    i_call_valid,
	input wire logic [7:0]              i_opcode,
	input wire logic                    i_exec_supervisory,
	input wire logic                    o_resume,
	input wire logic [7:0]              o_acc,
	input wire logic                    o_halt,
	input wire logic                    o_busy,
	input wire logic                    o_prog_mode,
	input wire logic [3:0]              o_stack_use,
	// ram and flash
	input wire logic [7:0]              o_ram_addr,
	input wire logic                    o_ram_we,
	input wire logic                    o_fl_req,
	input wire flash_call_pkg::fl_cmd_t o_fl_cmd,
	// apb
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic [31:0]             prdata,
	input wire logic                    pready,
	input wire logic                    pslverr
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	wire logic idle = !o_busy && !o_halt && !o_prog_mode;
	sequence s_call_in; idle && i_call_valid; endsequence
	sequence s_second_guard_key_wr; o_ram_we && o_ram_addr == flash_call_pkg::PRM_SECOND_GUARD_KEY; endsequence
	sequence s_resume_soon; ##[1:4] o_resume; endsequence
	call_take_a: assert property (s_call_in ##0 i_opcode == 8'h00 |=> o_busy) else $error("call missed");
	call_skip_a: assert property (s_call_in ##0 i_opcode != 8'h00 |=> !o_busy) else $error("bad opcode");
	halt_hold_a: assert property (o_halt |=> o_halt) else $error("halt dropped");
	resume_pulse_a: assert property (o_resume |=> !o_resume) else $error("resume long");
	resume_acc_a: assert property (o_resume |-> o_acc == 8'h00) else $error("acc not zero");
	rc_then_resume_a: assert property (s_second_guard_key_wr |-> s_resume_soon) else $error("no resume");
	apb_guard_a: assert property (psel && !penable && !i_exec_supervisory |=> pslverr && prdata == '0) else $error("guard");
	apb_ready_a: assert property (psel && penable |-> pready) else $error("ready low");
	stack_wr_a: assert property (o_fl_req && o_fl_cmd == flash_call_pkg::FL_PROG |-> o_stack_use == 4'ha) else $error("stk");
	stack_er_a: assert property (o_fl_req && o_fl_cmd == flash_call_pkg::FL_ERASE_BLK |-> o_stack_use == 4'h9) else $error("stk");
	whole_cmd_a: assert property (o_fl_req && o_stack_use == 4'hb |-> o_fl_cmd > flash_call_pkg::FL_ERASE_BLK
		&& o_fl_cmd != flash_call_pkg::FL_READ_AUX) else $error("aux touched");
endmodule // flash_call_asserts
`default_nettype wire

// File: verification/flash_ram_model.sv
// data ram and flash macro model at the far side of the call unit
`timescale 1ns/1ps
`default_nettype none
module flash_ram_model (
	// clock and pacing
	input  wire logic                    i_clk,
	input  wire logic                    i_slow,
	// data ram
	input  wire logic [7:0]              i_ram_addr,
	input  wire logic [7:0]              i_ram_wdata,
	input  wire logic                    i_ram_we,
	input  wire logic                    i_ram_re,
	output logic [7:0]                   o_ram_rdata,
	// flash macro, request fields held until next request
	input  wire logic                    i_fl_req,
	input  wire flash_call_pkg::fl_cmd_t i_fl_cmd,
	input  wire logic [12:0]             i_fl_addr,
	input  wire logic [7:0]              i_fl_wdata,
	output logic                         o_fl_done,
	output logic [7:0]                   o_fl_rdata
);
	logic [7:0] ram [256];
	logic [7:0] fl [8192];
	logic [2:0] wait_r = 3'h0;
	always @(posedge i_clk) begin
		// stale read data is inverted so it never looks valid
		o_ram_rdata <= i_ram_re ? ram[i_ram_addr] : ~o_ram_rdata;
		if (i_ram_we) ram[i_ram_addr] <= i_ram_wdata;
		o_fl_done <= 1'b0;
		o_fl_rdata <= ~o_fl_rdata;
		if (i_fl_req) wait_r <= i_slow ? 3'h5 : 3'h1;
		else if (wait_r > 3'h1) wait_r <= wait_r - 3'h1;
		else if (wait_r == 3'h1) begin
			wait_r <= 3'h0;
			o_fl_done <= 1'b1;
			case (i_fl_cmd)
				flash_call_pkg::FL_READ: o_fl_rdata <= fl[i_fl_addr];
				flash_call_pkg::FL_READ_AUX: o_fl_rdata <= {2'h2, i_fl_addr[5:0]};
				flash_call_pkg::FL_PROG: fl[i_fl_addr] <= i_fl_wdata;
				flash_call_pkg::FL_ERASE_BLK: for (int i = 0; i < 64; i++) fl[{i_fl_addr[12:6], i[5:0]}] <= 8'hff;
				flash_call_pkg::FL_ERASE_MACRO: foreach (fl[i]) fl[i] <= 8'hff;
				flash_call_pkg::FL_ZERO_MACRO: foreach (fl[i]) fl[i] <= 8'h00;
				default: ;
			endcase
		end
	end
endmodule // flash_ram_model
`default_nettype wire

// File: verification/supervisory_flash_call_unit_tb_top.sv
// self-checking bench for the supervisory flash call unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin failures++; \
	$display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module supervisory_flash_call_unit_tb_top;
	logic        i_clk = '0, i_rst = '1, i_call_valid = '0, i_exec_supervisory = '1, i_tq_valid = '0;
	logic        i_usb_dp = '0, i_usb_dm = '0, psel = '0, penable = '0, pwrite = '0, slow = '0, err;
	logic [7:0]  i_opcode = '0, i_acc = '0, i_sp = '0, i_tq_func = '0, i_tq_sp = '0, paddr = '0, sp;
	logic [31:0] pwdata = '0, rd, prdata;
	logic        o_resume, o_resume_to_boot, o_halt, o_busy, o_prog_mode, o_ram_we, o_ram_re, o_fl_req;
	logic        i_fl_done, pready, pslverr;
	logic [7:0]  o_acc, o_ram_addr, o_ram_wdata, i_ram_rdata, o_fl_wdata, i_fl_rdata;
	logic [3:0]  o_stack_use, o_fl_macro;
	logic [12:0] o_fl_addr;
	logic [5:0]  blk;
	flash_call_pkg::fl_cmd_t o_fl_cmd;
	int          failures = 0, num_checks = 0, cycles = 0, seed = 32'h6e2b_1508;
	logic [7:0]  fns [4] = '{8'h01, 8'h02, 8'h03, 8'h03};
	logic [1:0]  lvs [4] = '{2'h1, 2'h3, 2'h3, 2'h0};
	supervisory_flash_call_unit dut_u (.*);
	flash_ram_model mdl_u (.i_clk, .i_slow(slow), .i_ram_addr(o_ram_addr), .i_ram_wdata(o_ram_wdata),
		.i_ram_we(o_ram_we), .i_ram_re(o_ram_re), .o_ram_rdata(i_ram_rdata), .i_fl_req(o_fl_req),
		.i_fl_cmd(o_fl_cmd), .i_fl_addr(o_fl_addr), .i_fl_wdata(o_fl_wdata), .o_fl_done(i_fl_done),
		.o_fl_rdata(i_fl_rdata));
	initial forever #25 i_clk = ~i_clk;
	// a hang counts as a failure
	always @(posedge i_clk) if (++cycles == 60000) begin failures++; complete_run(); end
	task automatic complete_run();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic do_reset();
		i_rst <= 1'b1;
		repeat (6) @(posedge i_clk);
		i_rst <= 1'b0;
		repeat (3) @(posedge i_clk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge i_clk);
		penable <= 1'b1;
		do @(posedge i_clk); while (!pready);
		{rd, err} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask
	task automatic wait_end();
		int n;
		n = 0;
		do @(negedge i_clk); while (!o_resume && !o_halt && ++n < 20000);
	endtask
	task automatic call(input logic [7:0] fn, input logic [7:0] k1, input logic tq);
		sp = 8'($random(seed));
		mdl_u.ram[8'hf8] = k1;
		mdl_u.ram[8'hf9] = sp + 8'h03;
		@(posedge i_clk);
		{i_call_valid, i_tq_valid, i_opcode, i_acc, i_sp, i_tq_func, i_tq_sp} <= {!tq, tq, 8'h00, fn, sp, fn, sp};
		@(posedge i_clk);
		{i_call_valid, i_tq_valid} <= 2'b00;
		wait_end();
	endtask
	function automatic logic [15:0] csum(input logic [5:0] b);
		logic [15:0] s;
		s = '0;
		for (int i = 0; i < (b + 1) * 64; i++) s += 16'(mdl_u.fl[i]);
		return s;
	endfunction
	initial begin
		foreach (mdl_u.fl[i]) mdl_u.fl[i] = 8'($random(seed));
		do_reset();
		apb(1'b0, flash_call_pkg::REG_CONFIG, '0);
		`CHK("config", 32'h0000_0001, rd)
		i_exec_supervisory <= 1'b0;
		apb(1'b0, flash_call_pkg::REG_STATUS, '0);
		`CHK("guard", 1'b1, err)
		i_exec_supervisory <= 1'b1;
		apb(1'b0, 8'h10, '0);
		`CHK("unmapped", 1'b1, err)
		$display("test apb done");
		blk = 6'($random(seed));
		for (int i = 0; i < 64; i++) mdl_u.ram[i] = 8'($random(seed));
		{mdl_u.ram[8'hfa], mdl_u.ram[8'hfb]} = {2'h0, blk, 8'h00};
		call(flash_call_pkg::FN_WRITE, flash_call_pkg::FIRST_GUARD_KEY_VALUE, 1'b0);
		`CHK("wr rc", flash_call_pkg::RC_OK, mdl_u.ram[8'hf8])
		for (int i = 0; i < 64; i++) `CHK("wr data", mdl_u.ram[i], mdl_u.fl[{1'b0, blk, i[5:0]}])
		slow <= 1'b1;
		mdl_u.ram[8'hfb] = 8'h80;
		call(flash_call_pkg::FN_READ, flash_call_pkg::FIRST_GUARD_KEY_VALUE, 1'b0);
		for (int i = 0; i < 64; i++) `CHK("rd data", mdl_u.fl[{1'b0, blk, i[5:0]}], mdl_u.ram[8'h80 + i])
		$display("test write read done");
		apb(1'b1, flash_call_pkg::REG_PROT_SEL, 32'(blk));
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, flash_call_pkg::REG_PROT_LVL, 32'(lvs[k]));
			call(fns[k], flash_call_pkg::FIRST_GUARD_KEY_VALUE, 1'b0);
			`CHK("prot rc", {7'h0, k < 3}, mdl_u.ram[8'hf8])
			`CHK("prot second_guard_key", 8'h00, mdl_u.ram[8'hf9])
		end
		`CHK("erased", 8'hff, mdl_u.fl[{1'b0, blk, 6'h3f}])
		$display("test protection done");
		call(flash_call_pkg::FN_TABLE, flash_call_pkg::FIRST_GUARD_KEY_VALUE, 1'b0);
		`CHK("table second_guard_key", sp + 8'h03, mdl_u.ram[8'hf9])
		`CHK("table data", {2'h2, blk}, mdl_u.ram[8'hf8])
		mdl_u.ram[8'hfa] = 8'h02;
		call(flash_call_pkg::FN_CHECKSUM, flash_call_pkg::FIRST_GUARD_KEY_VALUE, 1'b0);
		`CHK("checksum", csum(6'h02), {mdl_u.ram[8'hf9], mdl_u.ram[8'hf8]})
		apb(1'b1, flash_call_pkg::REG_PROT_LVL, 32'h0000_0003);
		call(flash_call_pkg::FN_WHOLE, flash_call_pkg::FIRST_GUARD_KEY_VALUE, 1'b0);
		`CHK("whole", 8'hff, mdl_u.fl[13'($random(seed))])
		apb(1'b0, flash_call_pkg::REG_PROT_LVL, '0);
		`CHK("prot cleared", 32'h0000_0000, rd)
		call(flash_call_pkg::FN_BOOT, 8'h00, 1'b0);
		`CHK("boot", 9'h102, {o_resume_to_boot, mdl_u.ram[8'hf8]})
		$display("test erase boot done");
		@(posedge i_clk);
		{i_call_valid, i_opcode} <= {1'b1, 8'h40};
		@(posedge i_clk);
		i_call_valid <= 1'b0;
		@(negedge i_clk);
		`CHK("other opcode", 1'b0, o_busy)
		for (int k = 0; k < 2; k++) begin
			call(k ? 8'h04 : flash_call_pkg::FN_READ, k ? flash_call_pkg::FIRST_GUARD_KEY_VALUE : 8'h3b, 1'b0);
			`CHK("halt", 1'b1, o_halt)
			do_reset();
		end
		{i_usb_dp, i_usb_dm} <= 2'b11;
		repeat (8) @(posedge i_clk);
		`CHK("prog mode", 1'b1, o_prog_mode)
		call(8'h04, flash_call_pkg::FIRST_GUARD_KEY_VALUE, 1'b1);
		`CHK("fatal rc", flash_call_pkg::RC_FATAL, mdl_u.ram[8'hf8])
		$display("test halt prog done");
		complete_run();
	end
endmodule // supervisory_flash_call_unit_tb_top
bind supervisory_flash_call_unit flash_call_asserts chk_u (.*);
`default_nettype wire
